// ===== verilog/ntl_pkg.sv
`default_nettype none
package ntl_pkg;
    // Register byte offsets.
    localparam logic [7:0] NTL_OFF_BW2   = 8'h18;
    localparam logic [7:0] NTL_OFF_BW3   = 8'h1c;
    localparam logic [7:0] NTL_OFF_BW4   = 8'h20;
    localparam logic [7:0] NTL_OFF_BW5   = 8'h24;
    localparam logic [7:0] NTL_OFF_SSID  = 8'h2c;
    localparam logic [7:0] NTL_OFF_ROM   = 8'h30;
    localparam logic [7:0] NTL_OFF_CAPP  = 8'h34;
    localparam logic [7:0] NTL_OFF_INTR  = 8'h3c;
    localparam logic [7:0] NTL_OFF_PMCAP = 8'h40;
    localparam logic [7:0] NTL_OFF_PMCSR = 8'h44;

    // Field encodings and fixed values.
    localparam logic [1:0]  NTL_MAP_32   = 2'h0;
    localparam logic [1:0]  NTL_MAP_64   = 2'h2;
    localparam logic [1:0]  NTL_PS_D0    = 2'h0;
    localparam logic [1:0]  NTL_PS_D3HOT = 2'h3;
    localparam logic [7:0]  NTL_CAP_PTR  = 8'h40;
    localparam logic [7:0]  NTL_PM_ID    = 8'h01;
    localparam logic [7:0]  NTL_PM_NEXT  = 8'h48;
    localparam logic [2:0]  NTL_PM_VER   = 3'h3;
    localparam logic [7:0]  NTL_PIN_NONE = 8'h00;
    localparam logic [7:0]  NTL_PIN_INTA = 8'h01;
    localparam logic [4:0]  NTL_PME_MASK = 5'h19;
    // Subsystem identity defaults: arbitrary neutral values.
    localparam logic [15:0] NTL_SSVID_DEF = 16'h1234;
    localparam logic [15:0] NTL_SSID_DEF  = 16'h5678;

    // Field positions.
    localparam int NTL_BW_BASE_LSB  = 20;
    localparam int NTL_ROM_BASE_LSB = 14;

    // Strap/loader values supplied from outside (serial EEPROM or I2C loader).
    typedef struct packed {
        logic [15:0] ssvid;
        logic [15:0] ssid;
        logic [1:0]  bw2_type;
        logic        bw2_pf;
        logic [1:0]  bw4_type;
        logic        bw4_pf;
        logic        rom_32k;
        logic        rom_virt;
        logic        virt_rom_en;
        logic        pin_inta;
        logic [2:0]  aux_cur;
        logic [4:0]  pme_sup;
        logic        dsi;
    } ntl_cfg_t;

    // Configuration access request.
    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [7:0]  addr;
        logic [31:0] wdata;
    } ntl_req_t;

    // Whole block state.
    typedef struct packed {
        logic [11:0] bw2_base;
        logic [31:0] bw3;
        logic [11:0] bw4_base;
        logic [31:0] bw5;
        logic        rom_en;
        logic [17:0] rom_base;
        logic [7:0]  int_line;
        logic [1:0]  pstate;
        logic [31:0] rdata;
        logic        rvalid;
        logic        hit;
    } ntl_state_t;
endpackage
`default_nettype wire

// ===== verilog/ntl_link_cfg_regs.sv
// What this block does
// RULE1: Window two/four type reads 00b or 10b.
// RULE2: Window two bit0 zero, bit3 prefetchable.
// RULE3: Window three low fields writable only when 64-bit.
// RULE4: Paired window three holds upper 32 bits.
// RULE5: Unpaired window three base is bits 31:20.
// RULE6: Window five low fields writable only when 64-bit.
// RULE7: Paired window five holds upper 32 bits.
// RULE8: Subsystem identifiers read-only, loader overridable.
// RULE9: Option ROM enabled on one side only.
// RULE10: Link ROM enable reads zero if virtual enabled.
// RULE11: ROM size selects 16 KB or 32 KB.
// RULE12: ROM base writable only while enable set.
// RULE13: Capability pointer reads 40h.
// RULE14: Interrupt line is plain read/write storage.
// RULE15: Interrupt pin reads 00h or 01h.
// RULE16: Power header: id 01h, version 011b, next 48h.
// RULE17: D1 and D2 support bits read zero.
// RULE18: PME support default only bits 31,30,27.
// RULE19: Power state accepts D0 and D3hot.
// RULE20: Unsupported power state writes are discarded.
// RULE21: No-soft-reset reads one; no internal reset.
// RULE22: Loader should put zero in auxiliary current.
// RULE23: Dword accesses; reserved ignored, reads zero.
`timescale 1ns/100ps
`default_nettype none
module ntl_link_cfg_regs
    import ntl_pkg::*;
(
    input  wire logic        mclk_i,
    input  wire logic        srst_i,
    input  wire ntl_cfg_t    cfg_i,
    input  wire ntl_req_t    req_i,
    output logic             ack_o,
    output logic             hit_o,
    output logic [31:0]      rdata_o,
    output logic [1:0]       power_state_o,
    output logic             link_rom_en_o
);
    ntl_state_t s_q;
    ntl_state_t s_d;

    logic       bw23_64;
    logic       bw45_64;
    logic       rom_own;
    logic [1:0] bw2_type;
    logic [1:0] bw4_type;

    // Map types other than the two legal codes fall back to 32-bit.
    function automatic logic [1:0] legal_type(input logic [1:0] t);
        legal_type = (t == NTL_MAP_64) ? NTL_MAP_64 : NTL_MAP_32; // [RULE1]
    endfunction

    // Low window word: memory indicator zero, type, prefetch, base in 31:20.
    function automatic logic [31:0] win_word(input logic [11:0] base,
                                             input logic [1:0] t, input logic pf);
        win_word = {base, 16'h0000, pf, t, 1'b0}; // [RULE2]
    endfunction

    // Decodes the ten implemented dword offsets; anything else is unmapped.
    function automatic logic mapped(input logic [7:0] a);
        unique case (a)
            NTL_OFF_BW2, NTL_OFF_BW3, NTL_OFF_BW4, NTL_OFF_BW5, NTL_OFF_SSID,
            NTL_OFF_ROM, NTL_OFF_CAPP, NTL_OFF_INTR, NTL_OFF_PMCAP,
            NTL_OFF_PMCSR: mapped = 1'b1; // [RULE23]
            default: mapped = 1'b0;
        endcase
    endfunction

    // Pairing and ROM ownership derived from loader values.
    assign bw2_type = legal_type(cfg_i.bw2_type);
    assign bw4_type = legal_type(cfg_i.bw4_type);
    assign bw23_64  = (bw2_type == NTL_MAP_64);
    assign bw45_64  = (bw4_type == NTL_MAP_64);
    assign rom_own  = !cfg_i.rom_virt && !cfg_i.virt_rom_en; // [RULE9]

    // Register file next state and read mux.
    always_comb begin
        s_d        = s_q;
        s_d.rvalid = req_i.rd || req_i.wr;
        s_d.hit    = 1'b1;
        s_d.rdata  = 32'h0000_0000; // [RULE23]
        if (req_i.wr) begin
            unique case (req_i.addr)
                NTL_OFF_BW2: s_d.bw2_base = req_i.wdata[31:NTL_BW_BASE_LSB];
                NTL_OFF_BW3: begin
                    if (bw23_64) begin
                        s_d.bw3 = req_i.wdata; // [RULE3] [RULE4]
                    end else begin
                        s_d.bw3 = {req_i.wdata[31:NTL_BW_BASE_LSB], 20'h0_0000}; // [RULE5]
                    end
                end
                NTL_OFF_BW4: s_d.bw4_base = req_i.wdata[31:NTL_BW_BASE_LSB];
                NTL_OFF_BW5: begin
                    if (bw45_64) begin
                        s_d.bw5 = req_i.wdata; // [RULE6] [RULE7]
                    end else begin
                        s_d.bw5 = {req_i.wdata[31:NTL_BW_BASE_LSB], 20'h0_0000};
                    end
                end
                NTL_OFF_ROM: begin
                    // Base field accepts writes only while enable is already set.
                    if (rom_own) begin
                        s_d.rom_en = req_i.wdata[0];
                        if (s_q.rom_en) begin
                            s_d.rom_base = req_i.wdata[31:NTL_ROM_BASE_LSB]; // [RULE12]
                            if (cfg_i.rom_32k) begin
                                s_d.rom_base[0] = 1'b0; // [RULE11]
                            end
                        end
                    end
                end
                NTL_OFF_INTR: s_d.int_line = req_i.wdata[7:0]; // [RULE14]
                NTL_OFF_PMCSR: begin
                    if (req_i.wdata[1:0] == NTL_PS_D0 ||
                        req_i.wdata[1:0] == NTL_PS_D3HOT) begin
                        s_d.pstate = req_i.wdata[1:0]; // [RULE19]
                    end // Other codes complete but are dropped. [RULE20]
                end
                default: ;
            endcase
        end
        if (!rom_own) begin
            s_d.rom_en = 1'b0; // [RULE9]
        end
        if (req_i.rd) begin
            unique case (req_i.addr)
                NTL_OFF_BW2: s_d.rdata = win_word(s_q.bw2_base, bw2_type, cfg_i.bw2_pf);
                NTL_OFF_BW3: s_d.rdata = bw23_64 ? s_q.bw3 : {s_q.bw3[31:20], 20'h0_0000};
                NTL_OFF_BW4: s_d.rdata = win_word(s_q.bw4_base, bw4_type, cfg_i.bw4_pf);
                NTL_OFF_BW5: s_d.rdata = bw45_64 ? s_q.bw5 : {s_q.bw5[31:20], 20'h0_0000};
                NTL_OFF_SSID: s_d.rdata = {cfg_i.ssid, cfg_i.ssvid}; // [RULE8]
                NTL_OFF_ROM: begin
                    if (s_q.rom_en && rom_own) begin
                        s_d.rdata = {s_q.rom_base[17:1], s_q.rom_base[0] && !cfg_i.rom_32k,
                                     13'h0000, 1'b1}; // [RULE10] [RULE11] [RULE12]
                    end
                end
                NTL_OFF_CAPP: s_d.rdata = {24'h00_0000, NTL_CAP_PTR}; // [RULE13]
                NTL_OFF_INTR: s_d.rdata = {16'h0000,
                    (cfg_i.pin_inta ? NTL_PIN_INTA : NTL_PIN_NONE), s_q.int_line}; // [RULE15]
                NTL_OFF_PMCAP: s_d.rdata = {cfg_i.pme_sup & NTL_PME_MASK, 2'b00, // [RULE17] [RULE18]
                    cfg_i.aux_cur, cfg_i.dsi, 2'b00, NTL_PM_VER, NTL_PM_NEXT, NTL_PM_ID}; // [RULE16]
                NTL_OFF_PMCSR: s_d.rdata = {28'h000_0000, 1'b1, 1'b0, s_q.pstate}; // [RULE21]
                default: s_d.hit = 1'b0;
            endcase
        end else if (req_i.wr) begin
            s_d.hit = mapped(req_i.addr); // [RULE23]
        end
    end

    // State register; power transitions never reset the function. [RULE21]
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign ack_o         = s_q.rvalid;
    assign hit_o         = s_q.hit;
    assign rdata_o       = s_q.rdata;
    assign power_state_o = s_q.pstate;
    assign link_rom_en_o = s_q.rom_en;

    // Checks.
    logic past_ok;
    always_ff @(posedge mclk_i) begin
        past_ok <= !srst_i;
    end

    cap_ptr_a: assert property (@(posedge mclk_i) disable iff (srst_i) // [RULE13]
        req_i.rd && req_i.addr == NTL_OFF_CAPP |=> rdata_o == 32'h0000_0040)
        else $error("capability pointer wrong");
    bw2_low_a: assert property (@(posedge mclk_i) disable iff (srst_i) // [RULE2]
        req_i.rd && req_i.addr == NTL_OFF_BW2 |=> rdata_o[0] == 1'b0 && rdata_o[19:4] == 16'h0)
        else $error("window two low bits wrong");
    bw3_32_a: assert property (@(posedge mclk_i) disable iff (srst_i) // [RULE3]
        req_i.rd && req_i.addr == NTL_OFF_BW3 && !bw23_64 |=> rdata_o[19:0] == 20'h0)
        else $error("window three low not zero");
    bw5_32_a: assert property (@(posedge mclk_i) disable iff (srst_i) // [RULE6]
        req_i.rd && req_i.addr == NTL_OFF_BW5 && !bw45_64 |=> rdata_o[19:0] == 20'h0)
        else $error("window five low not zero");
    pm_hdr_a: assert property (@(posedge mclk_i) disable iff (srst_i) // [RULE16]
        req_i.rd && req_i.addr == NTL_OFF_PMCAP |=>
        rdata_o[18:0] == 19'h3_4801 && rdata_o[26:25] == 2'b00)
        else $error("power header wrong");
    ps_legal_a: assert property (@(posedge mclk_i) disable iff (srst_i) // [RULE19]
        power_state_o == NTL_PS_D0 || power_state_o == NTL_PS_D3HOT)
        else $error("illegal power state");
    ps_drop_a: assert property (@(posedge mclk_i) disable iff (srst_i || !past_ok) // [RULE20]
        req_i.wr && req_i.addr == NTL_OFF_PMCSR && req_i.wdata[1] != req_i.wdata[0]
        |=> $stable(power_state_o))
        else $error("unsupported state taken");
    rom_excl_a: assert property (@(posedge mclk_i) disable iff (srst_i) // [RULE10]
        cfg_i.virt_rom_en && req_i.rd && req_i.addr == NTL_OFF_ROM |=> rdata_o == 32'h0)
        else $error("rom enable visible while virtual owns");
    nsr_a: assert property (@(posedge mclk_i) disable iff (srst_i) // [RULE21]
        req_i.rd && req_i.addr == NTL_OFF_PMCSR |=> rdata_o[3] && rdata_o[7:4] == 4'h0)
        else $error("no soft reset bit wrong");

    d3_c: cover property (@(posedge mclk_i) disable iff (srst_i)
        power_state_o == NTL_PS_D3HOT ##1 power_state_o == NTL_PS_D0);
    pair_c: cover property (@(posedge mclk_i) disable iff (srst_i)
        bw23_64 && req_i.wr && req_i.addr == NTL_OFF_BW3);
    rom_c: cover property (@(posedge mclk_i) disable iff (srst_i) link_rom_en_o);

    // A 32 KB option ROM is read back with its base enabled.
    rom32_c: cover property (@(posedge mclk_i) disable iff (srst_i)
        link_rom_en_o && cfg_i.rom_32k && req_i.rd && req_i.addr == NTL_OFF_ROM);

    // An unsupported power state is written and dropped.
    drop_c: cover property (@(posedge mclk_i) disable iff (srst_i)
        req_i.wr && req_i.addr == NTL_OFF_PMCSR && req_i.wdata[1] != req_i.wdata[0]);

    // Window two always reports one of the two legal map type codes.
    bw2_type_a: assert property (@(posedge mclk_i) disable iff (srst_i) // [RULE1]
        req_i.rd && req_i.addr == NTL_OFF_BW2 |=>
        rdata_o[2:1] == NTL_MAP_32 || rdata_o[2:1] == NTL_MAP_64)
        else $error("window two map type illegal");

    // Window four always reports one of the two legal map type codes.
    bw4_type_a: assert property (@(posedge mclk_i) disable iff (srst_i) // [RULE1]
        req_i.rd && req_i.addr == NTL_OFF_BW4 |=>
        rdata_o[2:1] == NTL_MAP_32 || rdata_o[2:1] == NTL_MAP_64)
        else $error("window four map type illegal");

    // Window two reports the loaded prefetch attribute.
    bw2_pf_a: assert property (@(posedge mclk_i) disable iff (srst_i) // [RULE2]
        req_i.rd && req_i.addr == NTL_OFF_BW2 |=> rdata_o[3] == $past(cfg_i.bw2_pf))
        else $error("window two prefetch bit wrong");

    // Window four reads as a memory window with zero reserved bits.
    bw4_mem_a: assert property (@(posedge mclk_i) disable iff (srst_i) // [RULE23]
        req_i.rd && req_i.addr == NTL_OFF_BW4 |=>
        rdata_o[0] == 1'b0 && rdata_o[19:4] == 16'h0000)
        else $error("window four low bits wrong");

    // A window two write keeps only its base field.
    bw2_wr_a: assert property (@(posedge mclk_i) disable iff (srst_i) // [RULE23]
        req_i.wr && req_i.addr == NTL_OFF_BW2 |=>
        s_q.bw2_base == $past(req_i.wdata[31:NTL_BW_BASE_LSB]))
        else $error("window two base not stored");

    // A window four write keeps only its base field.
    bw4_wr_a: assert property (@(posedge mclk_i) disable iff (srst_i) // [RULE23]
        req_i.wr && req_i.addr == NTL_OFF_BW4 |=>
        s_q.bw4_base == $past(req_i.wdata[31:NTL_BW_BASE_LSB]))
        else $error("window four base not stored");

    // A paired window three stores the whole upper address word.
    bw3_wr64_a: assert property (@(posedge mclk_i) disable iff (srst_i) // [RULE4]
        req_i.wr && req_i.addr == NTL_OFF_BW3 && bw23_64 |=>
        s_q.bw3 == $past(req_i.wdata))
        else $error("window three upper word lost");

    // An unpaired window three stores only its base and keeps the low field clear.
    bw3_wr32_a: assert property (@(posedge mclk_i) disable iff (srst_i) // [RULE5]
        req_i.wr && req_i.addr == NTL_OFF_BW3 && !bw23_64 |=>
        s_q.bw3[31:NTL_BW_BASE_LSB] == $past(req_i.wdata[31:NTL_BW_BASE_LSB]) &&
        s_q.bw3[NTL_BW_BASE_LSB-1:0] == '0)
        else $error("window three base write wrong");

    // A paired window five stores the whole upper address word.
    bw5_wr64_a: assert property (@(posedge mclk_i) disable iff (srst_i) // [RULE7]
        req_i.wr && req_i.addr == NTL_OFF_BW5 && bw45_64 |=>
        s_q.bw5 == $past(req_i.wdata))
        else $error("window five upper word lost");

    // An unpaired window five ignores writes to its low fields.
    bw5_wr32_a: assert property (@(posedge mclk_i) disable iff (srst_i) // [RULE6]
        req_i.wr && req_i.addr == NTL_OFF_BW5 && !bw45_64 |=>
        s_q.bw5[31:NTL_BW_BASE_LSB] == $past(req_i.wdata[31:NTL_BW_BASE_LSB]) &&
        s_q.bw5[NTL_BW_BASE_LSB-1:0] == '0)
        else $error("window five base write wrong");

    // Subsystem identity reads straight from the loader values.
    ssid_a: assert property (@(posedge mclk_i) disable iff (srst_i) // [RULE8]
        req_i.rd && req_i.addr == NTL_OFF_SSID |=>
        rdata_o == {$past(cfg_i.ssid), $past(cfg_i.ssvid)})
        else $error("subsystem identity wrong");

    // The link side never keeps its ROM while the virtual side may own it.
    rom_one_a: assert property (@(posedge mclk_i) disable iff (srst_i) // [RULE9]
        cfg_i.virt_rom_en || cfg_i.rom_virt |=> !link_rom_en_o)
        else $error("rom enabled on both sides");

    // A 32 KB ROM never shows base bit 14.
    rom_32k_a: assert property (@(posedge mclk_i) disable iff (srst_i) // [RULE11]
        req_i.rd && req_i.addr == NTL_OFF_ROM && cfg_i.rom_32k |=>
        rdata_o[NTL_ROM_BASE_LSB] == 1'b0)
        else $error("rom base bit 14 visible at 32 KB");

    // A disabled ROM reads all zero.
    rom_off_a: assert property (@(posedge mclk_i) disable iff (srst_i) // [RULE12]
        req_i.rd && req_i.addr == NTL_OFF_ROM && !link_rom_en_o |=>
        rdata_o == 32'h0000_0000)
        else $error("disabled rom not zero");

    // The ROM base holds still when written while disabled.
    rom_base_a: assert property (@(posedge mclk_i) disable iff (srst_i || !past_ok) // [RULE12]
        req_i.wr && req_i.addr == NTL_OFF_ROM && !link_rom_en_o |=>
        $stable(s_q.rom_base))
        else $error("rom base written while disabled");

    // Reserved ROM bits 13:1 always read zero.
    rom_low_a: assert property (@(posedge mclk_i) disable iff (srst_i) // [RULE23]
        req_i.rd && req_i.addr == NTL_OFF_ROM |=>
        rdata_o[NTL_ROM_BASE_LSB-1:1] == '0)
        else $error("rom reserved bits set");

    // The interrupt line stores whatever software writes.
    int_line_a: assert property (@(posedge mclk_i) disable iff (srst_i) // [RULE14]
        req_i.wr && req_i.addr == NTL_OFF_INTR |=>
        s_q.int_line == $past(req_i.wdata[7:0]))
        else $error("interrupt line not stored");

    // The interrupt pin reads only the two allowed codes, upper half zero.
    int_pin_a: assert property (@(posedge mclk_i) disable iff (srst_i) // [RULE15]
        req_i.rd && req_i.addr == NTL_OFF_INTR |=>
        (rdata_o[15:8] == NTL_PIN_NONE || rdata_o[15:8] == NTL_PIN_INTA) &&
        rdata_o[31:16] == 16'h0000)
        else $error("interrupt pin code illegal");

    // Clock and reserved bits of the power header read zero.
    pm_rsvd_a: assert property (@(posedge mclk_i) disable iff (srst_i) // [RULE16]
        req_i.rd && req_i.addr == NTL_OFF_PMCAP |=>
        rdata_o[20:19] == 2'b00)
        else $error("power header reserved bits set");

    // Only bits 31, 30 and 27 of the PME support field may be set.
    pme_sup_a: assert property (@(posedge mclk_i) disable iff (srst_i) // [RULE18]
        req_i.rd && req_i.addr == NTL_OFF_PMCAP |=>
        rdata_o[29:28] == 2'b00)
        else $error("pme support bit outside mask");

    // A supported power state write is taken.
    ps_take_a: assert property (@(posedge mclk_i) disable iff (srst_i) // [RULE19]
        req_i.wr && req_i.addr == NTL_OFF_PMCSR && req_i.wdata[1] == req_i.wdata[0]
        |=> power_state_o == $past(req_i.wdata[1:0]))
        else $error("supported state not taken");

    // Upper and reserved control bits read zero.
    pmcsr_rsvd_a: assert property (@(posedge mclk_i) disable iff (srst_i) // [RULE23]
        req_i.rd && req_i.addr == NTL_OFF_PMCSR |=>
        rdata_o[31:8] == 24'h00_0000 && rdata_o[2] == 1'b0)
        else $error("power control reserved bits set");

    // Every access is acknowledged exactly one cycle later, and only then.
    ack_pulse_a: assert property (@(posedge mclk_i) disable iff (srst_i || !past_ok) // [RULE23]
        ack_o == $past(req_i.rd || req_i.wr))
        else $error("acknowledge timing wrong");

    // An unmapped read misses and returns zero.
    unmapped_a: assert property (@(posedge mclk_i) disable iff (srst_i) // [RULE23]
        req_i.rd && !mapped(req_i.addr) |=>
        !hit_o && rdata_o == 32'h0000_0000)
        else $error("unmapped read answered");

    // A mapped access reports a hit.
    mapped_hit_a: assert property (@(posedge mclk_i) disable iff (srst_i) // [RULE23]
        (req_i.rd || req_i.wr) && mapped(req_i.addr) |=> hit_o)
        else $error("mapped access missed");

    // Writes return no read data.
    wr_rdata_a: assert property (@(posedge mclk_i) disable iff (srst_i) // [RULE23]
        req_i.wr |=> rdata_o == 32'h0000_0000)
        else $error("write returned data");

    // Reset leaves the function idle, in D0, with the ROM off.
    reset_a: assert property (@(posedge mclk_i) // [RULE19]
        srst_i |=> !ack_o && power_state_o == NTL_PS_D0 && !link_rom_en_o)
        else $error("reset state wrong");
endmodule // ntl_link_cfg_regs
`default_nettype wire

// ===== sim/ntl_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module ntl_host_model
    import ntl_pkg::*;
(
    input  wire logic        mclk_i,
    output var ntl_req_t     req_o,
    input  wire logic        ack_i,
    input  wire logic        hit_i,
    input  wire logic [31:0] rdata_i
);
    // The bus starts idle.
    initial req_o = '0;

    // One dword access: raised after a falling edge, answer taken a cycle later.
    task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic h, output logic ok);
        @(negedge mclk_i);
        req_o = '{rd: !w, wr: w, addr: a, wdata: d};
        @(negedge mclk_i);
        ok = ack_i;
        h = hit_i;
        r = rdata_i;
        req_o = '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
    endtask
endmodule // ntl_host_model
`default_nettype wire

// ===== sim/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top
    import ntl_pkg::*;
;
    logic        mclk, srst, ack, hit, rom_en, h, ok;
    logic [31:0] rdata, r, wd;
    logic [1:0]  ps;
    ntl_cfg_t    cfg;
    ntl_req_t    req;
    int          error_cnt, compares, seed, k;
    logic [1:0]  pw [4] = '{2'h3, 2'h1, 2'h2, 2'h0};
    logic [1:0]  pe [4] = '{2'h3, 2'h3, 2'h3, 2'h0};

    ntl_link_cfg_regs u_dut (.mclk_i(mclk), .srst_i(srst), .cfg_i(cfg), .req_i(req),
        .ack_o(ack), .hit_o(hit), .rdata_o(rdata), .power_state_o(ps),
        .link_rom_en_o(rom_en));
    ntl_host_model u_host (.mclk_i(mclk), .req_o(req), .ack_i(ack), .hit_i(hit),
        .rdata_i(rdata));

    // Free-running 250 MHz clock.
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    // Expected window, upper window, ROM and power header readings.
    function automatic logic [31:0] f_bw(input logic [31:0] d, input logic [1:0] t,
                                         input logic pf);
        return {d[31:20], 16'h0000, pf, t, 1'b0};
    endfunction
    function automatic logic [31:0] f_hi(input logic [31:0] d, input logic [1:0] t);
        return (t === NTL_MAP_64) ? d : {d[31:20], 20'h0_0000};
    endfunction
    function automatic logic [31:0] f_rom(input logic [31:0] d, input logic big);
        return {d[31:15], d[14] & !big, 13'h0000, 1'b1};
    endfunction
    function automatic logic [31:0] f_pm(input ntl_cfg_t c);
        return {c.pme_sup[4:3], 2'h0, c.pme_sup[0], 2'h0, c.aux_cur, c.dsi, 2'h0, NTL_PM_VER,
                NTL_PM_NEXT, NTL_PM_ID};
    endfunction

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e) begin
            error_cnt++;
            $display("unexpected at %0t: got %h exp %h", $time, g, e);
        end
    endtask
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        u_host.acc(w, a, d, r, h, ok);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic eh);
        xfer(1'b0, a, 32'h0000_0000);
        chk({30'h0, ok, h}, {30'h0, 1'b1, eh});
        chk(r, e);
    endtask
    task automatic finish_test;
        $display("errors %0d compares %0d", error_cnt, compares);
        if (error_cnt == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Watchdog against a hung handshake.
    initial begin
        #20000;
        error_cnt++;
        finish_test;
    end

    // Main sequence.
    initial begin
        seed = 2218;
        srst = 1'b1;
        cfg = '0;
        cfg.ssvid = 16'($random(seed));
        cfg.ssid = 16'($random(seed));
        cfg.pme_sup = 5'($random(seed));
        cfg.dsi = 1'($random(seed));
        cfg.pin_inta = 1'b1;
        cfg.aux_cur = 3'h0;
        repeat (12) @(negedge mclk);
        srst = 1'b0;
        rd(NTL_OFF_CAPP, 32'h0000_0040, 1'b1);
        rd(NTL_OFF_PMCAP, f_pm(cfg), 1'b1);
        xfer(1'b1, NTL_OFF_SSID, ~{cfg.ssid, cfg.ssvid});
        rd(NTL_OFF_SSID, {cfg.ssid, cfg.ssvid}, 1'b1);
        rd(8'h28, 32'h0000_0000, 1'b0);
        for (k = 0; k < 4; k++) begin
            cfg.bw2_type = k[0] ? NTL_MAP_64 : NTL_MAP_32;
            cfg.bw4_type = k[0] ? NTL_MAP_32 : NTL_MAP_64;
            cfg.bw2_pf = 1'($random(seed));
            cfg.bw4_pf = 1'($random(seed));
            wd = (k > 1) ? 32'hffff_ffff : $random(seed);
            xfer(1'b1, NTL_OFF_BW2, wd);
            xfer(1'b1, NTL_OFF_BW3, ~wd);
            xfer(1'b1, NTL_OFF_BW4, wd);
            xfer(1'b1, NTL_OFF_BW5, ~wd);
            rd(NTL_OFF_BW2, f_bw(wd, cfg.bw2_type, cfg.bw2_pf), 1'b1);
            rd(NTL_OFF_BW3, f_hi(~wd, cfg.bw2_type), 1'b1);
            rd(NTL_OFF_BW4, f_bw(wd, cfg.bw4_type, cfg.bw4_pf), 1'b1);
            rd(NTL_OFF_BW5, f_hi(~wd, cfg.bw4_type), 1'b1);
        end
        for (k = 0; k < 2; k++) begin
            cfg.rom_32k = k[0];
            wd = $random(seed) | 32'h0000_4001;
            xfer(1'b1, NTL_OFF_ROM, 32'h0000_0001);
            xfer(1'b1, NTL_OFF_ROM, wd);
            rd(NTL_OFF_ROM, f_rom(wd, cfg.rom_32k), 1'b1);
            chk({31'h0, rom_en}, 32'h0000_0001);
            xfer(1'b1, NTL_OFF_ROM, 32'h0000_0000);
            rd(NTL_OFF_ROM, 32'h0000_0000, 1'b1);
        end
        xfer(1'b1, NTL_OFF_ROM, 32'h0000_0001);
        cfg.virt_rom_en = 1'b1;
        rd(NTL_OFF_ROM, 32'h0000_0000, 1'b1);
        chk({31'h0, rom_en}, 32'h0000_0000);
        wd = $random(seed);
        xfer(1'b1, NTL_OFF_INTR, wd);
        for (k = 0; k < 4; k++) begin
            xfer(1'b1, NTL_OFF_PMCSR, {$random(seed)} & 32'hffff_fffc | 32'(pw[k]));
            rd(NTL_OFF_PMCSR, 32'h0000_0008 | 32'(pe[k]), 1'b1);
            chk({30'h0, ps}, {30'h0, pe[k]});
        end
        rd(NTL_OFF_INTR, {16'h0000, NTL_PIN_INTA, wd[7:0]}, 1'b1);
        cfg.pin_inta = 1'b0;
        rd(NTL_OFF_INTR, {16'h0000, NTL_PIN_NONE, wd[7:0]}, 1'b1);
        finish_test;
    end
endmodule // tb_top
`default_nettype wire
